// ===== design/xbar_defs.svh
// constants for the bus matrix master port: transfer codes, responses, reset values
`ifndef XBAR_DEFS_SVH
`define XBAR_DEFS_SVH

`define XBAR_TRANS_W        2
`define XBAR_TRANS_IDLE     2'h0
`define XBAR_TRANS_NONSEQ   2'h2
`define XBAR_RESP_OKAY      1'h0
`define XBAR_RESP_ERROR     1'h1
`define XBAR_SIZE_W         3
`define XBAR_BURST_W        3
`define XBAR_PROT_W         4
`define XBAR_MASTER_W       4
`define XBAR_ADDR_W_DEF     32
`define XBAR_ADDR_W_MIN     32
`define XBAR_ADDR_W_MAX     64
`define XBAR_DATA_W_DEF     32
`define XBAR_USER_W_DEF     4
`define XBAR_RST_SELECT     1'h0
`define XBAR_RST_READY      1'h1
`define XBAR_RST_SIZE       3'h0
`define XBAR_RST_BURST      3'h0
`define XBAR_RST_PROT       4'h0
`define XBAR_RST_MASTER     4'h0

`endif

// ===== design/xbar_pkg.sv
// types shared by the bus matrix master port files
package xbar_pkg;

    // one-hot sequencer states of the master port
    typedef enum logic [3:0] {
        ST_IDLE = 4'h1,
        ST_ADDR = 4'h2,
        ST_DATA = 4'h4,
        ST_ERR  = 4'h8
    } port_state_t;

endpackage

// ===== design/xbar_return_stage.sv
// return stage: registers read data, response and read sideband toward the upstream master
`timescale 1ns/100ps
`include "xbar_defs.svh"

module xbar_return_stage #(
    parameter int DATA_W = `XBAR_DATA_W_DEF,
    parameter int UW     = 1
) (
    input  wire logic              core_clk,
    input  wire logic              rst,
    input  wire logic              load,
    input  wire logic              clear,
    input  wire logic [DATA_W-1:0] rdata_in,
    input  wire logic              resp_in,
    input  wire logic [UW-1:0]     ruser_in,
    output logic      [DATA_W-1:0] rdata_out,
    output logic                   resp_out,
    output logic      [UW-1:0]     ruser_out
);

    logic [DATA_W-1:0] rdata_reg, rdata_next;
    logic              resp_reg,  resp_next;
    logic [UW-1:0]     ruser_reg, ruser_next;

    // capture on completion, drop the response back to okay when idle
    always_comb begin
        rdata_next = rdata_reg;
        resp_next  = resp_reg;
        ruser_next = ruser_reg;
        if (load) begin
            rdata_next = rdata_in;
            resp_next  = resp_in;
            ruser_next = ruser_in;
        end else if (clear) begin
            resp_next = `XBAR_RESP_OKAY;
        end
    end

    // register the return values
    always_ff @(posedge core_clk) begin
        if (rst) begin
            rdata_reg <= '0;
            resp_reg  <= `XBAR_RESP_OKAY;
            ruser_reg <= '0;
        end else begin
            rdata_reg <= rdata_next;
            resp_reg  <= resp_next;
            ruser_reg <= ruser_next;
        end
    end

    assign rdata_out = rdata_reg;
    assign resp_out  = resp_reg;
    assign ruser_out = ruser_reg;

endmodule // xbar_return_stage

// ===== design/xbar_master_port.sv
// bus matrix master port: forwards one upstream transfer to a downstream slave bus
`timescale 1ns/100ps
`include "xbar_defs.svh"

module xbar_master_port #(
    parameter int ADDR_W = `XBAR_ADDR_W_DEF,
    parameter int DATA_W = `XBAR_DATA_W_DEF,
    parameter int USER_W = `XBAR_USER_W_DEF
) (
    input  wire logic                                   core_clk,
    input  wire logic                                   rst,
    // upstream slave port
    input  wire logic                                   in_sel,
    input  wire logic [`XBAR_TRANS_W-1:0]               in_trans,
    input  wire logic [ADDR_W-1:0]                      in_addr,
    input  wire logic                                   in_write,
    input  wire logic [`XBAR_SIZE_W-1:0]                in_size,
    input  wire logic [`XBAR_BURST_W-1:0]               in_burst,
    input  wire logic [`XBAR_PROT_W-1:0]                in_prot,
    input  wire logic [`XBAR_MASTER_W-1:0]              in_master,
    input  wire logic                                   in_lock,
    input  wire logic                                   in_ready,
    input  wire logic [DATA_W-1:0]                      in_wdata,
    input  wire logic [((USER_W == 0) ? 1 : USER_W)-1:0] in_addr_sideband,
    input  wire logic [((USER_W == 0) ? 1 : USER_W)-1:0] in_wdata_sideband,
    output logic                                        upstream_ready_feedback,
    output logic                                        in_resp,
    output logic      [DATA_W-1:0]                      in_rdata,
    output logic      [((USER_W == 0) ? 1 : USER_W)-1:0] in_rdata_sideband,
    // downstream master port
    output logic                                        port_slave_select,
    output logic      [`XBAR_TRANS_W-1:0]               port_trans,
    output logic      [ADDR_W-1:0]                      port_addr,
    output logic                                        port_write_flag,
    output logic      [`XBAR_SIZE_W-1:0]                port_transfer_size,
    output logic      [`XBAR_BURST_W-1:0]               port_burst,
    output logic      [`XBAR_PROT_W-1:0]                port_prot,
    output logic      [`XBAR_MASTER_W-1:0]              forwarded_master_id,
    output logic                                        forwarded_lock_flag,
    output logic      [DATA_W-1:0]                      port_write_bus,
    output logic                                        port_ready_broadcast,
    output logic      [((USER_W == 0) ? 1 : USER_W)-1:0] out_addr_sideband,
    output logic      [((USER_W == 0) ? 1 : USER_W)-1:0] out_wdata_sideband,
    input  wire logic                                   port_slave_ready,
    input  wire logic                                   port_slave_response,
    input  wire logic [DATA_W-1:0]                      port_read_bus,
    input  wire logic [((USER_W == 0) ? 1 : USER_W)-1:0] out_rdata_sideband
);

    localparam int UW = (USER_W == 0) ? 1 : USER_W;
    localparam logic USER_ON = (USER_W != 0);

    xbar_pkg::port_state_t state_reg, state_next;

    logic                       sel_reg,   sel_next;
    logic [`XBAR_TRANS_W-1:0]   trans_reg, trans_next;
    logic [ADDR_W-1:0]          addr_reg,  addr_next;
    logic                       write_reg, write_next;
    logic [`XBAR_SIZE_W-1:0]    size_reg,  size_next;
    logic [`XBAR_BURST_W-1:0]   burst_reg, burst_next;
    logic [`XBAR_PROT_W-1:0]    prot_reg,  prot_next;
    logic [`XBAR_MASTER_W-1:0]  mid_reg,   mid_next;
    logic                       lock_reg,  lock_next;
    logic [DATA_W-1:0]          wdata_reg, wdata_next;
    logic                       bcast_reg, bcast_next;
    logic                       rdyfb_reg, rdyfb_next;
    logic [UW-1:0]              auser_reg, auser_next;
    logic [UW-1:0]              wuser_reg, wuser_next;
    logic                       accept;
    logic                       done;

    // a transfer is taken when selected, active and the upstream bus is ready
    assign accept = (state_reg == xbar_pkg::ST_IDLE) && in_sel && in_trans[1] && in_ready;
    assign done   = (state_reg == xbar_pkg::ST_DATA) && port_slave_ready;

    // sequencer and master port address/data phase values
    always_comb begin
        state_next = state_reg;
        sel_next   = sel_reg;
        trans_next = trans_reg;
        addr_next  = addr_reg;
        write_next = write_reg;
        size_next  = size_reg;
        burst_next = burst_reg;
        prot_next  = prot_reg;
        mid_next   = mid_reg;
        lock_next  = lock_reg;
        wdata_next = wdata_reg;
        bcast_next = bcast_reg;
        rdyfb_next = rdyfb_reg;
        auser_next = auser_reg;
        wuser_next = wuser_reg;
        unique case (state_reg)
            xbar_pkg::ST_IDLE: begin
                bcast_next = 1'b1;
                rdyfb_next = 1'b1;
                if (accept) begin
                    state_next = xbar_pkg::ST_ADDR;
                    sel_next   = 1'b1;
                    trans_next = `XBAR_TRANS_NONSEQ;
                    addr_next  = in_addr;
                    write_next = in_write;
                    size_next  = in_size;
                    burst_next = in_burst;
                    prot_next  = in_prot;
                    mid_next   = in_master;
                    lock_next  = in_lock;
                    auser_next = USER_ON ? in_addr_sideband : '0;
                    rdyfb_next = 1'b0;
                end
            end
            xbar_pkg::ST_ADDR: begin
                // slaves sample the address phase on this edge
                state_next = xbar_pkg::ST_DATA;
                sel_next   = 1'b0;
                trans_next = `XBAR_TRANS_IDLE;
                bcast_next = 1'b0;
                wdata_next = in_wdata;
                wuser_next = USER_ON ? in_wdata_sideband : '0;
            end
            xbar_pkg::ST_DATA: begin
                if (port_slave_ready) begin
                    bcast_next = 1'b1;
                    if (port_slave_response == `XBAR_RESP_ERROR) begin
                        state_next = xbar_pkg::ST_ERR; // first cycle of a two-cycle error
                    end else begin
                        state_next = xbar_pkg::ST_IDLE;
                        rdyfb_next = 1'b1;
                    end
                end
            end
            xbar_pkg::ST_ERR: begin
                state_next = xbar_pkg::ST_IDLE;
                rdyfb_next = 1'b1;
            end
            default: begin
                state_next = xbar_pkg::ST_IDLE;
            end
        endcase
    end

    // register the sequencer and all master port outputs
    always_ff @(posedge core_clk) begin
        if (rst) begin
            state_reg <= xbar_pkg::ST_IDLE;
            sel_reg   <= `XBAR_RST_SELECT;
            trans_reg <= `XBAR_TRANS_IDLE;
            addr_reg  <= '0;
            write_reg <= 1'b0;
            size_reg  <= `XBAR_RST_SIZE;
            burst_reg <= `XBAR_RST_BURST;
            prot_reg  <= `XBAR_RST_PROT;
            mid_reg   <= `XBAR_RST_MASTER;
            lock_reg  <= 1'b0;
            wdata_reg <= '0;
            bcast_reg <= `XBAR_RST_READY;
            rdyfb_reg <= `XBAR_RST_READY;
            auser_reg <= '0;
            wuser_reg <= '0;
        end else begin
            state_reg <= state_next;
            sel_reg   <= sel_next;
            trans_reg <= trans_next;
            addr_reg  <= addr_next;
            write_reg <= write_next;
            size_reg  <= size_next;
            burst_reg <= burst_next;
            prot_reg  <= prot_next;
            mid_reg   <= mid_next;
            lock_reg  <= lock_next;
            wdata_reg <= wdata_next;
            bcast_reg <= bcast_next;
            rdyfb_reg <= rdyfb_next;
            auser_reg <= auser_next;
            wuser_reg <= wuser_next;
        end
    end

    // response path back to the owning upstream master
    xbar_return_stage #(
        .DATA_W (DATA_W),
        .UW     (UW)
    ) u_return (
        .core_clk  (core_clk),
        .rst       (rst),
        .load      (done),
        .clear     (state_reg == xbar_pkg::ST_IDLE),
        .rdata_in  (port_read_bus),
        .resp_in   (port_slave_response),
        .ruser_in  (USER_ON ? out_rdata_sideband : {UW{1'b0}}),
        .rdata_out (in_rdata),
        .resp_out  (in_resp),
        .ruser_out (in_rdata_sideband)
    );

    assign upstream_ready_feedback = rdyfb_reg;
    assign port_slave_select       = sel_reg;
    assign port_trans              = trans_reg;
    assign port_addr               = addr_reg;
    assign port_write_flag         = write_reg;
    assign port_transfer_size      = size_reg;
    assign port_burst              = burst_reg;
    assign port_prot               = prot_reg;
    assign forwarded_master_id     = mid_reg;
    assign forwarded_lock_flag     = lock_reg;
    assign port_write_bus          = wdata_reg;
    assign port_ready_broadcast    = bcast_reg;
    assign out_addr_sideband       = auser_reg;
    assign out_wdata_sideband      = wuser_reg;

    // ==========================================================
    // checks
    bcast_addr_a: assert property (@(posedge core_clk) disable iff (rst)
        (state_reg == xbar_pkg::ST_ADDR) |-> port_ready_broadcast ##1 !port_ready_broadcast)
        else $error("broadcast ready wrong around address phase");
    resp_fwd_a: assert property (@(posedge core_clk) disable iff (rst)
        (done && !port_slave_response) |=> (upstream_ready_feedback && !in_resp
        && in_rdata == $past(port_read_bus)))
        else $error("okay response not forwarded");
    select_pulse_a: assert property (@(posedge core_clk) disable iff (rst)
        accept |=> (port_slave_select && port_trans == `XBAR_TRANS_NONSEQ) ##1 !port_slave_select)
        else $error("select not one address phase");
    wdata_fwd_a: assert property (@(posedge core_clk) disable iff (rst)
        (state_reg == xbar_pkg::ST_ADDR) |=> port_write_bus == $past(in_wdata))
        else $error("write data not forwarded");
    auser_fwd_a: assert property (@(posedge core_clk) disable iff (rst || !USER_ON)
        accept |=> out_addr_sideband == $past(in_addr_sideband))
        else $error("address sideband not forwarded");
    wuser_fwd_a: assert property (@(posedge core_clk) disable iff (rst || !USER_ON)
        (state_reg == xbar_pkg::ST_ADDR) |=> out_wdata_sideband == $past(in_wdata_sideband))
        else $error("write sideband not forwarded");
    user_off_a: assert property (@(posedge core_clk) disable iff (rst)
        !USER_ON |-> (out_addr_sideband == '0 && out_wdata_sideband == '0 && in_rdata_sideband == '0))
        else $error("sideband active with zero width");
    addr_fwd_a: assert property (@(posedge core_clk) disable iff (rst)
        accept |=> port_addr == $past(in_addr))
        else $error("address not forwarded at full width");
    err_two_cycle_a: assert property (@(posedge core_clk) disable iff (rst)
        (done && port_slave_response) |=> (!upstream_ready_feedback && in_resp)
        ##1 (upstream_ready_feedback && in_resp))
        else $error("error response not two cycles");
    master_id_a: assert property (@(posedge core_clk) disable iff (rst)
        accept |=> (forwarded_master_id == $past(in_master) && forwarded_lock_flag == $past(in_lock)))
        else $error("master id or lock not forwarded");
    reset_idle_a: assert property (@(posedge core_clk)
        $past(rst) |-> (!port_slave_select && port_trans == `XBAR_TRANS_IDLE && upstream_ready_feedback))
        else $error("master port not idle after reset");

endmodule // xbar_master_port

// ===== dv/xbar_slave_model.sv
// downstream slave model: answers each forwarded transfer with set waits and an optional error
`timescale 1ns/100ps

module xbar_slave_model #(
    parameter int DATA_W = 64,
    parameter int UW     = 4
) (
    input  wire logic              core_clk,
    input  wire logic              rst,
    input  wire logic              port_slave_select,
    input  wire logic [1:0]        port_trans,
    input  wire logic              port_write_flag,
    input  wire logic [DATA_W-1:0] port_write_bus,
    input  wire logic              port_ready_broadcast,
    input  wire logic [UW-1:0]     out_wdata_sideband,
    input  wire logic [3:0]        wait_cfg,
    input  wire logic              err_cfg,
    input  wire logic [DATA_W-1:0] rd_value,
    input  wire logic [UW-1:0]     rd_user,
    output logic                   port_slave_ready,
    output logic                   port_slave_response,
    output logic      [DATA_W-1:0] port_read_bus,
    output logic      [UW-1:0]     out_rdata_sideband,
    output logic      [DATA_W-1:0] got_wdata,
    output logic      [UW-1:0]     got_wuser
);
    logic       active_reg;
    logic       wr_reg;
    logic       err2_reg;
    logic [3:0] cnt_reg;
    logic       done;

    // address sampled only on a selected active transfer with the broadcast ready high
    always_ff @(posedge core_clk) begin
        if (rst) begin
            active_reg <= 1'h0;
            wr_reg     <= 1'h0;
            err2_reg   <= 1'h0;
            cnt_reg    <= 4'h0;
        end else if (!active_reg) begin
            if (port_slave_select && port_trans[1] && port_ready_broadcast) begin
                active_reg <= 1'h1;
                wr_reg     <= port_write_flag;
                err2_reg   <= 1'h0;
                cnt_reg    <= wait_cfg;
            end
        end else if (cnt_reg != 4'h0) begin
            cnt_reg <= cnt_reg - 4'h1;
        end else if (err_cfg && !err2_reg) begin
            err2_reg <= 1'h1; // two-cycle error
        end else begin
            active_reg <= 1'h0;
            if (wr_reg) begin
                got_wdata <= port_write_bus;
                got_wuser <= out_wdata_sideband;
            end
        end
    end

    // ready high and okay when idle; read data only valid in its completing cycle
    assign done                = active_reg && cnt_reg == 4'h0 && (!err_cfg || err2_reg);
    assign port_slave_ready    = !active_reg || done;
    assign port_slave_response = active_reg && cnt_reg == 4'h0 && err_cfg;
    assign port_read_bus       = (done && !wr_reg) ? rd_value : ~rd_value;
    assign out_rdata_sideband  = (done && !wr_reg) ? rd_user : ~rd_user;
endmodule // xbar_slave_model

// ===== dv/bus_matrix_master_port_sideband_tb_top.sv
// testbench for the bus matrix master port with a downstream slave model
`timescale 1ns/100ps
`include "xbar_defs.svh"

module bus_matrix_master_port_sideband_tb_top;
    logic        core_clk, rst, in_sel, in_write, in_lock, in_resp, err_cfg;
    logic [1:0]  in_trans, port_trans;
    logic [39:0] in_addr, port_addr;
    logic [2:0]  in_size, in_burst, port_transfer_size, port_burst;
    logic [3:0]  in_prot, in_master, port_prot, forwarded_master_id, wait_cfg, rd_user, got_wuser;
    logic [3:0]  in_addr_sideband, in_wdata_sideband, in_rdata_sideband, out_addr_sideband;
    logic [3:0]  out_wdata_sideband, out_rdata_sideband;
    logic [63:0] in_wdata, in_rdata, port_write_bus, port_read_bus, rd_value, got_wdata;
    logic        upstream_ready_feedback, port_slave_select, port_write_flag, forwarded_lock_flag;
    logic        port_ready_broadcast, port_slave_ready, port_slave_response;
    logic        in_ready;
    int          bad_count, compares, cycles;

    xbar_master_port #(.ADDR_W(40), .DATA_W(64), .USER_W(4)) i_xbar_master_port (.*);
    xbar_slave_model #(.DATA_W(64), .UW(4)) i_xbar_slave_model (.*);

    // ==========================================
    // clock, timeout, comparison and verdict
    initial begin
        core_clk = 1'h0;
        forever #10 core_clk = ~core_clk;
    end
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 2000) begin
            bad_count++;
            conclude();
        end
    end
    task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
        compares++;
        if (seen !== exp) begin
            bad_count++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic conclude();
        $display("comparisons %0d mismatches %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask

    // ==========================================
    // one upstream transfer, walked cycle by cycle from a falling edge
    task automatic xfer(input logic wr, input logic [39:0] a, input int w, input logic e);
        int k;
        wait_cfg = w[3:0];
        err_cfg = e;
        rd_value = {~a[31:0], a[31:0]};
        rd_user = a[3:0] ^ 4'h5;
        in_sel = 1'h1;
        in_trans = `XBAR_TRANS_NONSEQ;
        in_addr = a;
        in_write = wr;
        in_size = a[6:4];
        in_burst = a[2:0];
        in_prot = a[3:0];
        in_master = a[7:4];
        in_lock = a[8];
        in_addr_sideband = a[11:8];
        @(negedge core_clk);
        chk(port_slave_select, 1);
        chk(port_trans, `XBAR_TRANS_NONSEQ);
        chk(port_addr, a);
        chk({port_write_flag, port_transfer_size, port_burst, port_prot}, {wr, a[6:4], a[2:0], a[3:0]});
        chk({forwarded_lock_flag, forwarded_master_id}, a[8:4]);
        chk(out_addr_sideband, a[11:8]);
        chk(upstream_ready_feedback, 0);
        in_sel = 1'h0;
        in_trans = `XBAR_TRANS_IDLE;
        in_wdata = {a[31:0], ~a[31:0]};
        in_wdata_sideband = a[15:12];
        @(negedge core_clk);
        chk(port_slave_select, 0);
        chk(port_ready_broadcast, 0);
        if (wr) chk(port_write_bus, in_wdata);
        if (wr) chk(out_wdata_sideband, a[15:12]);
        for (k = 0; k < w + e; k++) begin // the slave's first error cycle is one more wait
            @(negedge core_clk);
            chk(upstream_ready_feedback, 0);
        end
        @(negedge core_clk);
        chk(in_resp, e ? `XBAR_RESP_ERROR : `XBAR_RESP_OKAY);
        chk(upstream_ready_feedback, e ? 64'h0 : 64'h1);
        if (e) begin
            @(negedge core_clk);
            chk({upstream_ready_feedback, in_resp}, 2'h3);
        end
        if (!wr && !e) chk(in_rdata, rd_value);
        if (!wr && !e) chk(in_rdata_sideband, rd_user);
        if (wr && !e) chk({got_wuser, got_wdata}, {a[15:12], in_wdata});
        chk(port_ready_broadcast, 1);
    endtask

    // ==========================================
    // scenarios
    task automatic t_reset();
        chk({port_slave_select, port_trans, upstream_ready_feedback, port_ready_broadcast, in_resp}, 6'h06);
        $display("test reset done");
    endtask
    task automatic t_idle_sel();
        in_sel = 1'h1;
        repeat (3) begin
            @(negedge core_clk);
            chk(port_slave_select, 0);
        end
        // an active request while the upstream bus is not ready must not be taken
        in_trans = `XBAR_TRANS_NONSEQ;
        in_ready = 1'h0;
        repeat (2) begin
            @(negedge core_clk);
            chk({port_slave_select, upstream_ready_feedback}, 2'h1);
        end
        in_sel = 1'h0;
        in_trans = `XBAR_TRANS_IDLE;
        in_ready = 1'h1;
        @(negedge core_clk);
        $display("test idle select done");
    endtask
    task automatic t_write();
        xfer(1'h1, 40'h80_1234_5678, 0, 1'h0);
        $display("test write done");
    endtask
    task automatic t_read_wait();
        xfer(1'h0, 40'hff_0000_01f4, 3, 1'h0);
        $display("test read wait done");
    endtask
    task automatic t_error_then_read();
        xfer(1'h1, 40'h01_aaaa_5550, 2, 1'h1);
        xfer(1'h0, 40'h00_ffff_fffc, 0, 1'h0);
        $display("test error then read done");
    endtask
    task automatic t_back_to_back();
        xfer(1'h0, 40'h7f_8000_0000, 0, 1'h0);
        xfer(1'h1, 40'h00_0000_0004, 1, 1'h0);
        $display("test back to back done");
    endtask

    initial begin
        {in_sel, in_write, in_lock, err_cfg, in_trans, in_addr, in_size, in_burst} = '0;
        in_ready = 1'h1;
        {in_prot, in_master, wait_cfg, rd_user, in_addr_sideband, in_wdata_sideband, in_wdata, rd_value} = '0;
        rst = 1'h1;
        repeat (3) @(negedge core_clk);
        rst = 1'h0;
        t_reset();
        t_idle_sel();
        t_write();
        t_read_wait();
        t_error_then_read();
        t_back_to_back();
        conclude();
    end
endmodule // bus_matrix_master_port_sideband_tb_top
